// ### design/e1ftc_ctrl.sv
// e1 transmit/receive control bank: host registers plus the datapath selections they steer
//////////////////////////////////////////////////////////////////////////////
module e1ftc_ctrl #(
    parameter int DEBOUNCE_CYCLES = e1ftc_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // host register port
    input wire logic cs_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // backplane streams, one time slot byte per clock
    input wire logic [7:0] serial_data_input_i,
    output logic [7:0] serial_data_output_o,
    output logic serial_data_output_oe_n_o,
    input wire logic [7:0] signaling_stream_input_i,
    output logic [7:0] signaling_stream_output_o,
    output logic signaling_stream_output_oe_n_o,
    // receive framer side
    input wire logic [7:0] rx_data_i,
    input wire logic [3:0] rx_sig_nibble_i,
    input wire logic sig_multiframe_i,
    input wire logic crc_multiframe_i,
    output logic rx_multiframe_marker_o,
    // transmit framer side
    input wire logic [7:0] tx_framer_byte_i,
    input wire logic ts0_i,
    output logic [7:0] tx_payload_o,
    output logic [7:0] tx_ch16_o,
    // line side bipolar signals
    input wire logic rx_line_positive_i,
    input wire logic rx_line_negative_i,
    input wire logic tx_enc_positive_i,
    input wire logic tx_enc_negative_i,
    output logic tx_line_positive_o,
    output logic tx_line_negative_o,
    output logic rcv_in_positive_o,
    output logic rcv_in_negative_o,
    // time slot zero non-frame-alignment bits
    input wire logic auto_remote_alarm_control_i,
    input wire logic auto_alarm_i,
    input wire logic tx_transparent_select_i,
    input wire logic [4:0] sa_buffer_i,
    input wire logic [4:0] data_link_bits_i,
    output logic [5:0] tx_nfas_bits_o,
    // coding controls
    output logic rx_zero_substitution_enable_o,
    output logic tx_zero_substitution_enable_o
);

    //////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] sig_ctrl_r; // signaling_and_output_control
    logic [7:0] loop_ctrl_r; // coding_and_loopback_control
    logic [7:0] nat_ctrl_r; // national_bits_alarm_control
    logic [7:0] mf_sel_r; // multiframe_and_link_select
    logic [7:0] rdata_nxt;

    // decode of the host strobes
    wire wr_en = cs_i && wr_i;
    wire rd_en = cs_i && rd_i;
    wire hit_sig = addr_i == e1ftc_pkg::SIG_OUT_CTRL_OFS;
    wire hit_loop = addr_i == e1ftc_pkg::CODE_LOOP_CTRL_OFS;
    wire hit_nat = addr_i == e1ftc_pkg::NAT_ALARM_CTRL_OFS;
    wire hit_mf = addr_i == e1ftc_pkg::MF_LINK_SEL_OFS;

    // named control fields
    wire serial_out_drive_enable = sig_ctrl_r[e1ftc_pkg::SERIAL_OUT_EN_BIT];
    wire signaling_out_drive_enable = sig_ctrl_r[e1ftc_pkg::SIG_OUT_EN_BIT];
    wire tx_common_channel_select = sig_ctrl_r[e1ftc_pkg::COMMON_CHAN_BIT];
    wire signaling_debounce_select = sig_ctrl_r[e1ftc_pkg::DEBOUNCE_SEL_BIT];
    wire nibble_upper_half_select = sig_ctrl_r[e1ftc_pkg::NIBBLE_UPPER_BIT];
    wire metallic_loop_enable = loop_ctrl_r[e1ftc_pkg::METALLIC_LOOP_BIT];
    wire digital_loop_enable = loop_ctrl_r[e1ftc_pkg::DIGITAL_LOOP_BIT];
    wire remote_loop_enable = loop_ctrl_r[e1ftc_pkg::REMOTE_LOOP_BIT];
    wire backplane_loop_enable = loop_ctrl_r[e1ftc_pkg::BACKPLANE_LOOP_BIT];
    wire payload_loop_enable = loop_ctrl_r[e1ftc_pkg::PAYLOAD_LOOP_BIT];
    wire tx_remote_alarm_bit = nat_ctrl_r[e1ftc_pkg::REMOTE_ALARM_BIT];
    wire [4:0] tx_national_use_bits = nat_ctrl_r[e1ftc_pkg::NAT_USE_LSB +: e1ftc_pkg::SA_BITS];
    wire rx_multiframe_marker_select = mf_sel_r[e1ftc_pkg::MF_MARKER_SEL_BIT];
    wire national_bit_source_select = mf_sel_r[e1ftc_pkg::NAT_SRC_SEL_BIT];
    wire [4:0] data_link_position_select = mf_sel_r[e1ftc_pkg::DL_SEL_LSB +: e1ftc_pkg::SA_BITS];

    // read mux; unmapped offsets read zero
    assign rdata_nxt = hit_sig ? sig_ctrl_r :
                       hit_loop ? loop_ctrl_r :
                       hit_nat ? nat_ctrl_r :
                       hit_mf ? mf_sel_r : 8'h00;

    // register writes, masked so unused bits never store
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sig_ctrl_r <= e1ftc_pkg::SIG_OUT_CTRL_RST;
            loop_ctrl_r <= e1ftc_pkg::CODE_LOOP_CTRL_RST;
            nat_ctrl_r <= e1ftc_pkg::NAT_ALARM_CTRL_RST;
            mf_sel_r <= e1ftc_pkg::MF_LINK_SEL_RST;
        end
        else if (wr_en)
        begin
            if (hit_sig) sig_ctrl_r <= wdata_i & e1ftc_pkg::SIG_OUT_CTRL_MASK;
            if (hit_loop) loop_ctrl_r <= wdata_i & e1ftc_pkg::CODE_LOOP_CTRL_MASK;
            if (hit_nat) nat_ctrl_r <= wdata_i & e1ftc_pkg::NAT_ALARM_CTRL_MASK;
            if (hit_mf) mf_sel_r <= wdata_i & e1ftc_pkg::MF_LINK_SEL_MASK;
        end
    end

    // read data register, held between reads
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= 8'h00;
        else if (rd_en)
            rdata_o <= rdata_nxt;
    end

    //////////////////////////////////////////////////////////////////////////
    // received signaling debounce
    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [CW-1:0] DEB_LAST = CW'(DEBOUNCE_CYCLES - 1);
    logic [3:0] sig_cand_r; // candidate new state
    logic [3:0] sig_deb_r; // accepted state
    logic [CW-1:0] deb_cnt_r; // cycles the candidate has held
    wire sig_changed = rx_sig_nibble_i != sig_cand_r;

    // a change restarts the window; the multiframe skew adds up to 2 ms upstream
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sig_cand_r <= 4'h0;
            sig_deb_r <= 4'h0;
            deb_cnt_r <= '0;
        end
        else if (!signaling_debounce_select)
        begin
            sig_cand_r <= rx_sig_nibble_i;
            sig_deb_r <= rx_sig_nibble_i;
            deb_cnt_r <= '0;
        end
        else if (sig_changed)
        begin
            sig_cand_r <= rx_sig_nibble_i;
            deb_cnt_r <= '0;
        end
        else if (deb_cnt_r == DEB_LAST)
            sig_deb_r <= sig_cand_r;
        else
            deb_cnt_r <= deb_cnt_r + CW'(1);
    end

    //////////////////////////////////////////////////////////////////////////
    // backplane side selections
    logic [3:0] tx_abcd_r; // internal transmit abcd register
    wire [3:0] sig_in_nibble = nibble_upper_half_select ? signaling_stream_input_i[7:4] :
                               signaling_stream_input_i[3:0];
    wire [7:0] sig_out_nxt = nibble_upper_half_select ? {sig_deb_r, 4'h0} : {4'h0, sig_deb_r};
    // backplane loop wins, then digital loop
    wire [7:0] sdo_nxt = backplane_loop_enable ? serial_data_input_i :
                         digital_loop_enable ? tx_payload_o : rx_data_i;
    wire [7:0] ch16_nxt = tx_common_channel_select ? serial_data_input_i : {tx_abcd_r, tx_abcd_r};

    // backplane outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_abcd_r <= 4'h0;
            serial_data_output_o <= 8'h00;
            serial_data_output_oe_n_o <= 1'b1;
            signaling_stream_output_o <= 8'h00;
            signaling_stream_output_oe_n_o <= 1'b1;
            tx_ch16_o <= 8'h00;
        end
        else
        begin
            tx_abcd_r <= sig_in_nibble;
            serial_data_output_o <= sdo_nxt;
            serial_data_output_oe_n_o <= !serial_out_drive_enable;
            signaling_stream_output_o <= sig_out_nxt;
            signaling_stream_output_oe_n_o <= !signaling_out_drive_enable;
            tx_ch16_o <= ch16_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // transmit payload and line side selections
    // payload loop keeps slot zero from the framer
    wire [7:0] payload_nxt = payload_loop_enable ? (ts0_i ? tx_framer_byte_i : rx_data_i) :
                             tx_transparent_select_i ? serial_data_input_i : tx_framer_byte_i;
    wire line_pos_nxt = remote_loop_enable ? rx_line_positive_i : tx_enc_positive_i;
    wire line_neg_nxt = remote_loop_enable ? rx_line_negative_i : tx_enc_negative_i;
    // metallic loop feeds the transmit line signals to the receiver inputs
    wire rcv_pos_nxt = metallic_loop_enable ? line_pos_nxt : rx_line_positive_i;
    wire rcv_neg_nxt = metallic_loop_enable ? line_neg_nxt : rx_line_negative_i;

    // time slot zero non-frame-alignment bits
    // transparent forces sa4 only
    wire [4:0] dl_sel = tx_transparent_select_i ? e1ftc_pkg::SA4_ONLY : data_link_position_select;
    wire [4:0] nat_src = national_bit_source_select ? sa_buffer_i : tx_national_use_bits;
    // per position data link or national bit
    wire [4:0] sa_nxt = (dl_sel & data_link_bits_i) | (~dl_sel & nat_src);
    // alarm bit ignored without auto control
    wire alarm_nxt = auto_remote_alarm_control_i ? tx_remote_alarm_bit : auto_alarm_i;
    wire mf_nxt = rx_multiframe_marker_select ? crc_multiframe_i : sig_multiframe_i;

    // line side and framing outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_payload_o <= 8'h00;
            tx_line_positive_o <= 1'b0;
            tx_line_negative_o <= 1'b0;
            rcv_in_positive_o <= 1'b0;
            rcv_in_negative_o <= 1'b0;
            tx_nfas_bits_o <= 6'h00;
            rx_multiframe_marker_o <= 1'b0;
            rx_zero_substitution_enable_o <= 1'b0;
            tx_zero_substitution_enable_o <= 1'b0;
        end
        else
        begin
            tx_payload_o <= payload_nxt;
            tx_line_positive_o <= line_pos_nxt;
            tx_line_negative_o <= line_neg_nxt;
            rcv_in_positive_o <= rcv_pos_nxt;
            rcv_in_negative_o <= rcv_neg_nxt;
            tx_nfas_bits_o <= {alarm_nxt, sa_nxt};
            rx_multiframe_marker_o <= mf_nxt;
            rx_zero_substitution_enable_o <= loop_ctrl_r[e1ftc_pkg::RX_ZSUB_BIT];
            tx_zero_substitution_enable_o <= loop_ctrl_r[e1ftc_pkg::TX_ZSUB_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_serial_out_drive: assert property (
        wr_en && hit_sig ##1 1'b1 |=> serial_data_output_oe_n_o == !$past(wdata_i[7], 2))
        else $error("serial output enable mismatch");
    chk_sig_out_drive: assert property (
        wr_en && hit_sig ##1 !(wr_en && hit_sig) |=> signaling_stream_output_oe_n_o == !$past(wdata_i[6], 2))
        else $error("signaling output enable mismatch");
    chk_ch16_common: assert property (
        tx_common_channel_select |=> tx_ch16_o == $past(serial_data_input_i))
        else $error("channel 16 not common channel data");
    chk_debounce_bypass: assert property (
        !signaling_debounce_select |=> sig_deb_r == $past(rx_sig_nibble_i))
        else $error("debounce not bypassed");
    chk_debounce_hold: assert property (
        signaling_debounce_select && sig_changed |=> sig_deb_r == $past(sig_deb_r))
        else $error("debounced state changed early");
    chk_nibble_upper: assert property (
        nibble_upper_half_select |=> signaling_stream_output_o[3:0] == 4'h0)
        else $error("nibble not in upper half");
    chk_backplane_loop: assert property (
        backplane_loop_enable |=> serial_data_output_o == $past(serial_data_input_i))
        else $error("backplane loop broken");
    chk_digital_loop: assert property (
        digital_loop_enable && !backplane_loop_enable && !payload_loop_enable
        && tx_transparent_select_i ##1 1'b1
        |=> serial_data_output_o == $past(serial_data_input_i, 2))
        else $error("digital loop copy wrong");
    chk_remote_loop: assert property (
        remote_loop_enable |=> tx_line_positive_o == $past(rx_line_positive_i)
        && tx_line_negative_o == $past(rx_line_negative_i))
        else $error("remote loop broken");
    chk_metallic_loop: assert property (
        metallic_loop_enable && !remote_loop_enable |=> rcv_in_positive_o == $past(tx_enc_positive_i))
        else $error("metallic loop broken");
    chk_payload_ts0: assert property (
        payload_loop_enable && ts0_i |=> tx_payload_o == $past(tx_framer_byte_i))
        else $error("slot zero looped back");
    chk_alarm_bit: assert property (
        !auto_remote_alarm_control_i |=> tx_nfas_bits_o[5] == $past(auto_alarm_i))
        else $error("alarm control not ignored");
    chk_sa4_forced: assert property (
        tx_transparent_select_i |=> tx_nfas_bits_o[4] == $past(data_link_bits_i[4]))
        else $error("sa4 not data link in transparent");
    chk_marker_select: assert property (
        rx_multiframe_marker_select |=> rx_multiframe_marker_o == $past(crc_multiframe_i))
        else $error("marker not crc-4 aligned");
    chk_nat_use_src: assert property (
        !national_bit_source_select && !tx_transparent_select_i && data_link_position_select == 5'h00
        |=> tx_nfas_bits_o[4:0] == $past(tx_national_use_bits))
        else $error("national use bits not sent");
    chk_nat_source: assert property (
        national_bit_source_select && !tx_transparent_select_i && data_link_position_select == 5'h00
        |=> tx_nfas_bits_o[4:0] == $past(sa_buffer_i))
        else $error("national bits not from buffer page");
    chk_dl_position: assert property (
        !tx_transparent_select_i && data_link_position_select[0]
        |=> tx_nfas_bits_o[0] == $past(data_link_bits_i[0]))
        else $error("selected sa position not data link");
    chk_coding_select: assert property (
        1'b1 |=> rx_zero_substitution_enable_o == $past(loop_ctrl_r[e1ftc_pkg::RX_ZSUB_BIT])
        && tx_zero_substitution_enable_o == $past(loop_ctrl_r[e1ftc_pkg::TX_ZSUB_BIT]))
        else $error("coding select not applied");
    chk_unused_zero: assert property (
        rd_en && hit_loop |=> rdata_o[4] == 1'b0)
        else $error("unused bit reads one");

    cov_backplane_loop: cover property (backplane_loop_enable ##1 !backplane_loop_enable);
    cov_debounce_accept: cover property (signaling_debounce_select && deb_cnt_r == DEB_LAST);
    cov_payload_loop: cover property (payload_loop_enable && ts0_i);
    cov_transparent_dl: cover property (tx_transparent_select_i && national_bit_source_select);

endmodule : e1ftc_ctrl

// ### design/e1ftc_pkg.sv
// package: register map, field positions and timing constants of the e1 control bank
package e1ftc_pkg;
    // register offsets on the 8-bit host port
    localparam logic [7:0] SIG_OUT_CTRL_OFS = 8'h14;
    localparam logic [7:0] CODE_LOOP_CTRL_OFS = 8'h15;
    localparam logic [7:0] NAT_ALARM_CTRL_OFS = 8'h16;
    localparam logic [7:0] MF_LINK_SEL_OFS = 8'h17;
    // writable bit masks, unused positions stay zero
    localparam logic [7:0] SIG_OUT_CTRL_MASK = 8'hf8;
    localparam logic [7:0] CODE_LOOP_CTRL_MASK = 8'hef;
    localparam logic [7:0] NAT_ALARM_CTRL_MASK = 8'h3f;
    localparam logic [7:0] MF_LINK_SEL_MASK = 8'h7f;
    // reset values
    localparam logic [7:0] SIG_OUT_CTRL_RST = 8'h00;
    localparam logic [7:0] CODE_LOOP_CTRL_RST = 8'h00;
    localparam logic [7:0] NAT_ALARM_CTRL_RST = 8'h00;
    localparam logic [7:0] MF_LINK_SEL_RST = 8'h00;
    // signaling_and_output_control fields
    localparam int SERIAL_OUT_EN_BIT = 7;
    localparam int SIG_OUT_EN_BIT = 6;
    localparam int COMMON_CHAN_BIT = 5;
    localparam int DEBOUNCE_SEL_BIT = 4;
    localparam int NIBBLE_UPPER_BIT = 3;
    // coding_and_loopback_control fields
    localparam int RX_ZSUB_BIT = 7;
    localparam int METALLIC_LOOP_BIT = 6;
    localparam int TX_ZSUB_BIT = 5;
    localparam int DIGITAL_LOOP_BIT = 3;
    localparam int REMOTE_LOOP_BIT = 2;
    localparam int BACKPLANE_LOOP_BIT = 1;
    localparam int PAYLOAD_LOOP_BIT = 0;
    // national_bits_alarm_control fields
    localparam int REMOTE_ALARM_BIT = 5;
    localparam int NAT_USE_LSB = 0;
    // multiframe_and_link_select fields
    localparam int MF_MARKER_SEL_BIT = 6;
    localparam int NAT_SRC_SEL_BIT = 5;
    localparam int DL_SEL_LSB = 0;
    localparam int SA_BITS = 5;
    // sa4 is the msb of each five-bit sa field
    localparam logic [4:0] SA4_ONLY = 5'h10;
    // debounce timing
    localparam longint CLK_PERIOD_NS = 100;
    localparam longint DEBOUNCE_NS = 14_000_000;
    localparam int DEBOUNCE_CYCLES = int'(DEBOUNCE_NS / CLK_PERIOD_NS);
endpackage : e1ftc_pkg

// ### tb/e1ftc_bp_model.sv
// backplane source model: time slot bytes and signaling nibbles toward the control bank
module e1ftc_bp_model (
    // clock
    input wire logic clk_i,
    // nibble half chosen by the host setting
    input wire logic upper_i,
    // streams toward the device
    output logic [7:0] sdi_o,
    output logic [7:0] ssi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // free running slot counter, one slot per clock
    logic [7:0] cnt_r = 8'h00;
    assign sdi_o = cnt_r;
    // nibble half placement
    // the other half carries a moving pattern so a wrong half never matches by luck
    assign ssi_o = upper_i ? {cnt_r[3:0], ~cnt_r[7:4]} : {~cnt_r[7:4], cnt_r[3:0]};
    // launched off the falling edge, stable at the sampling edge
    always @(negedge clk_i)
    begin
        cnt_r <= cnt_r + 8'h01;
    end
endmodule // e1ftc_bp_model

// ### tb/e1ftc_ctrl_tb.sv
// self-checking testbench of the e1 control bank
module e1ftc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // short debounce keeps the run brief
    localparam int DBC = 8;
    logic clk_i, srst_i, cs_i, wr_i, rd_i, ts0, auto_ctl, xparent, aalm, upper_sel, mf_sig, mf_crc;
    logic [7:0] addr_i, wdata_i, rdata_o, sdi, sdo, ssi, sso, rx_data, pay, ch16, fr_byte, cap_sdi, cap_pay;
    // serial input two edges back, for the abcd path that passes one more register
    logic [7:0] cap_sd2;
    logic sdo_oe_n, sso_oe_n, mf_o, rxp, rxn, encp, encn, txp, txn, rcvp, rcvn, rxz, txz;
    logic [3:0] nib;
    logic [4:0] sabuf, dlb;
    logic [5:0] nfas;
    logic [1:0] tx_x;
    int err_count, num_checks;
    // writable bits of the four words
    logic [7:0] reg_mask [4] = '{8'hf8, 8'hef, 8'h3f, 8'h7f};
    logic [7:0] line_cfg [6] = '{8'h00, 8'h04, 8'h40, 8'ha0, 8'h80, 8'h44};
    logic [7:0] sig_cfg [3] = '{8'hc0, 8'hc8, 8'he0};
    // {auto alarm control, transparent, multiframe word, expected alarm and sa bits}
    logic [15:0] nat_tbl [6] = '{{2'b10, 8'h00, 6'h2a}, {2'b00, 8'h00, 6'h0a}, {2'b10, 8'h20, 6'h35},
        {2'b10, 8'h23, 6'h34}, {2'b11, 8'h03, 6'h3a}, {2'b10, 8'h40, 6'h2a}};
    //////////////////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // values the design sampled at the last rising edge
    always @(posedge clk_i)
    begin
        cap_sdi <= sdi;
        cap_sd2 <= cap_sdi;
        cap_pay <= pay;
    end
    e1ftc_bp_model e1ftc_bp_model_i (.clk_i(clk_i), .upper_i(upper_sel), .sdi_o(sdi), .ssi_o(ssi));
    e1ftc_ctrl #(.DEBOUNCE_CYCLES(DBC)) e1ftc_ctrl_i (
        .clk_i(clk_i), .srst_i(srst_i), .cs_i(cs_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .serial_data_input_i(sdi), .serial_data_output_o(sdo),
        .serial_data_output_oe_n_o(sdo_oe_n), .signaling_stream_input_i(ssi), .signaling_stream_output_o(sso),
        .signaling_stream_output_oe_n_o(sso_oe_n), .rx_data_i(rx_data), .rx_sig_nibble_i(nib),
        .sig_multiframe_i(mf_sig), .crc_multiframe_i(mf_crc), .rx_multiframe_marker_o(mf_o),
        .tx_framer_byte_i(fr_byte), .ts0_i(ts0), .tx_payload_o(pay), .tx_ch16_o(ch16),
        .rx_line_positive_i(rxp), .rx_line_negative_i(rxn), .tx_enc_positive_i(encp),
        .tx_enc_negative_i(encn), .tx_line_positive_o(txp), .tx_line_negative_o(txn),
        .rcv_in_positive_o(rcvp), .rcv_in_negative_o(rcvn), .auto_remote_alarm_control_i(auto_ctl),
        .auto_alarm_i(aalm), .tx_transparent_select_i(xparent), .sa_buffer_i(sabuf),
        .data_link_bits_i(dlb), .tx_nfas_bits_o(nfas), .rx_zero_substitution_enable_o(rxz),
        .tx_zero_substitution_enable_o(txz)
    );
    //////////////////////////////////////////////////////////////////////////////
    // compare and count, case equality so unknowns fail
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one host access held across one rising edge; a read compares d with the answer
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        cs_i = 1'b1;
        wr_i = w;
        rd_i = !w;
        addr_i = a;
        wdata_i = d;
        @(negedge clk_i);
        cs_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        if (!w)
            chk(rdata_o, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic final_report();
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog, well beyond the fewer than two hundred cycles the tests need
    initial
    begin
        #200_000;
        err_count++;
        final_report();
    end
    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cs_i, wr_i, rd_i, addr_i, wdata_i, ts0, auto_ctl, xparent, aalm, upper_sel, mf_sig, mf_crc, nib} = '0;
        {rxp, rxn, encp, encn} = 4'h0;
        rx_data = 8'h5a;
        fr_byte = 8'h3c;
        sabuf = 5'h15;
        dlb = 5'h1c;
        srst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        srst_i = 1'b0;
        // outputs float out of reset, registers read back zero and drop unused bits
        chk(sdo_oe_n, 1'b1);
        chk(sso_oe_n, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b0, 8'h14 + i[7:0], 8'h00);
            acc(1'b1, 8'h14 + i[7:0], 8'hff);
            acc(1'b0, 8'h14 + i[7:0], reg_mask[i]);
        end
        acc(1'b1, 8'h13, 8'hff);
        acc(1'b0, 8'h13, 8'h00);
        // each drive enable on its own
        acc(1'b1, 8'h14, 8'h80);
        cyc(2);
        chk(sdo_oe_n, 1'b0);
        chk(sso_oe_n, 1'b1);
        acc(1'b1, 8'h14, 8'h40);
        cyc(2);
        chk(sdo_oe_n, 1'b1);
        chk(sso_oe_n, 1'b0);
        // serial output and payload paths
        acc(1'b1, 8'h15, 8'h00);
        cyc(2);
        chk(sdo, 8'h5a);
        chk(pay, 8'h3c);
        acc(1'b1, 8'h15, 8'h02);
        repeat (4)
        begin
            @(negedge clk_i);
            chk(sdo, cap_sdi);
        end
        xparent = 1'b1;
        acc(1'b1, 8'h15, 8'h08);
        repeat (4)
        begin
            @(negedge clk_i);
            chk(pay, cap_sdi);
            chk(sdo, cap_pay);
        end
        xparent = 1'b0;
        acc(1'b1, 8'h15, 8'h01);
        for (int t = 0; t < 2; t++)
        begin
            ts0 = t[0];
            cyc(3);
            chk(pay, t[0] ? 8'h3c : 8'h5a);
        end
        ts0 = 1'b0;
        // line side loops and coding, both input patterns
        for (int i = 0; i < 6; i++)
        begin
            {rxp, rxn, encp, encn} = i[0] ? 4'b1001 : 4'b0110;
            acc(1'b1, 8'h15, line_cfg[i]);
            cyc(3);
            tx_x = line_cfg[i][2] ? {rxp, rxn} : {encp, encn};
            chk({txp, txn}, tx_x);
            chk({rcvp, rcvn}, line_cfg[i][6] ? tx_x : {rxp, rxn});
            chk({rxz, txz}, {line_cfg[i][7], line_cfg[i][5]});
        end
        // alarm, national bits, data link and marker selection
        acc(1'b1, 8'h16, 8'h2a);
        for (int i = 0; i < 6; i++)
        begin
            {auto_ctl, xparent} = nat_tbl[i][15:14];
            {mf_sig, mf_crc} = {i[0], ~i[0]};
            acc(1'b1, 8'h17, nat_tbl[i][13:6]);
            cyc(3);
            chk({2'b00, nfas}, {2'b00, nat_tbl[i][5:0]});
            chk(mf_o, nat_tbl[i][12] ? mf_crc : mf_sig);
        end
        xparent = 1'b0;
        // channel 16 source and nibble half, lower, upper, then common channel
        nib = 4'h9;
        for (int m = 0; m < 3; m++)
        begin
            acc(1'b1, 8'h14, sig_cfg[m]);
            // source moves its nibble on the edge after the write, in step with the register
            upper_sel = sig_cfg[m][3];
            repeat (6)
            begin
                @(negedge clk_i);
                chk(ch16, m == 2 ? cap_sdi : {2{cap_sd2[3:0]}});
            end
            chk(sso, upper_sel ? {nib, 4'h0} : {4'h0, nib});
        end
        // debounce: a short glitch is dropped, a held change is taken late
        acc(1'b1, 8'h14, 8'hd0);
        nib = 4'h6;
        cyc(3);
        chk(sso, 8'h09);
        nib = 4'h9;
        cyc(DBC + 4);
        chk(sso, 8'h09);
        nib = 4'h6;
        cyc(3);
        chk(sso, 8'h09);
        cyc(DBC);
        chk(sso, 8'h06);
        acc(1'b1, 8'h14, 8'hc0);
        nib = 4'h3;
        cyc(3);
        chk(sso, 8'h03);
        final_report();
    end
endmodule // e1ftc_ctrl_tb
